//--- src/fmc_consts.svh
// constants of the frame memory codec: sizes, codes and counts
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH

`define FMC_BLK_BYTES 32
`define FMC_BLK_LAST 5'h1F
`define FMC_FIFO_WIDTH 8
`define FMC_FIFO_DEPTH 64
`define FMC_SRAM_AW 16
`define FMC_CNT_W 24
`define FMC_RD_WAIT 3'h4
`define FMC_RAW_SIZE 6'h21
`define FMC_MAP_SIZE 6'h05
`define FMC_EMIT_MAP0 6'h01
`define FMC_EMIT_DATA0 6'h05
`define FMC_EMIT_END 6'h24
`define FMC_PASS_END 6'h03
`define FMC_HDR_RAW 8'h00
`define FMC_HDR_LEFT 8'h01
`define FMC_HDR_UP 8'h02
`define FMC_HDR_AVG 8'h03
`define FMC_HDR_XOR 8'h04

`endif

//--- src/fmc_pkg.sv
// types of the frame memory codec
`default_nettype none
package fmc_pkg;
   typedef enum logic [1:0] {
      FMC_MODE_PASS = 2'h0,
      FMC_MODE_BYTE = 2'h1,
      FMC_MODE_BILEVEL = 2'h2
   } fmc_mode_e;

   typedef enum logic [2:0] {
      FMC_ENC_RAW = 3'h0,
      FMC_ENC_LEFT = 3'h1,
      FMC_ENC_UP = 3'h2,
      FMC_ENC_AVG = 3'h3,
      FMC_ENC_XOR = 3'h4
   } fmc_enc_e;

   typedef enum logic [6:0] {
      FMC_ST_IDLE = 7'h01,
      FMC_ST_FETCH = 7'h02,
      FMC_ST_SRD = 7'h04,
      FMC_ST_SWR = 7'h08,
      FMC_ST_EVAL = 7'h10,
      FMC_ST_EMIT = 7'h20,
      FMC_ST_FINISH = 7'h40
   } fmc_state_e;

   typedef struct packed {
      fmc_mode_e mode;
      logic to_video;
      logic [23:0] out_limit;
      logic [15:0] line_len;
   } fmc_cmd_s;
endpackage : fmc_pkg
`default_nettype wire

//--- src/fmc_codec.sv
// frame memory codec: copier, byte difference codec, bilevel codec, fifo
//
// Contract
// - copier and two codecs, one selected per operation, sharing input and fifo.
// - input words come from the dma side; every output byte enters a 64-byte fifo.
// - fifo drains either to memory or to video, never both in one operation.
// - codec input consumed in 32-byte blocks of 8 words, copier input one word at a time; supplier pads input.
// - programmable output byte count; emission stops once it is reached.
// - engine-finished flag rises when coding ends, even with bytes still queued.
// - all-drained flag rises after engine-finished, once the fifo is empty and the last output byte is accepted.
// - one operation at a time; start is ignored while busy.
// - copier forwards every input byte unchanged.
// - byte codec scores three difference types per block, uses the best.
// - when no difference type shrinks the block, raw bytes are emitted.
// - encoding type chosen and recorded per block in a header byte.
// - current line written to line memory; differences taken against line above.
// - first line uses in-line differences only, without scoring.
// - line memory address is 16 bits, lines up to 65,535 bytes.
// - output length up to 16,777,215 bytes per operation.
// - bilevel codec handles one-bit-per-pixel images.
// - bilevel codec shares line memory, widths up to 524,280 pixels.
// - bilevel images up to 65,535 lines.
// - line memory driven by 16-bit address, 8-bit data, write and read strobes.
`include "fmc_consts.svh"
`default_nettype none

module fmc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 64
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in,
   output logic empty_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;
   logic do_wr;
   logic do_rd;

   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty = (wr_q == rd_q);
   assign do_wr = in_valid_in && !full;
   assign do_rd = out_ready_in && !empty;
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign empty_out = empty;
   assign out_data_out = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (do_wr) wr_q <= wr_q + 1'b1;
         if (do_rd) rd_q <= rd_q + 1'b1;
      end
   end

   // storage has no reset; contents are only read behind the pointers
   always_ff @(posedge clk_in) begin
      if (do_wr) mem_q[wr_q[AW-1:0]] <= in_data_in;
   end
endmodule : fmc_fifo

module fmc_codec
   import fmc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // operation control
   input wire logic start_in,
   input wire fmc_cmd_s cmd_in,
   output logic busy_out,
   output logic proc_done_out,
   output logic done_all_out,
   // input words from the dma side
   input wire logic in_valid_in,
   input wire logic [31:0] in_word_in,
   input wire logic in_last_in,
   output logic in_ready_out,
   // output bytes
   output logic [7:0] out_data_out,
   output logic out_mem_valid_out,
   input wire logic out_mem_ready_in,
   output logic out_vid_valid_out,
   input wire logic out_vid_ready_in,
   // line memory
   output logic [15:0] line_sram_addr_out,
   output logic [7:0] line_sram_data_out,
   output logic line_sram_data_oe_out,
   input wire logic [7:0] line_sram_data_in,
   output logic line_sram_write_strobe_out,
   output logic line_sram_output_strobe_out
);
   fmc_state_e state_q;
   fmc_cmd_s cmd_q;
   fmc_enc_e enc_q;
   logic [31:0] word_q;
   logic last_q;
   logic [4:0] bi_q;
   logic [7:0] cur_q [`FMC_BLK_BYTES];
   logic [7:0] up_q [`FMC_BLK_BYTES];
   logic [`FMC_SRAM_AW-1:0] col_q;
   logic first_line_q;
   logic blk_first_q;
   logic [7:0] left_q;
   logic [5:0] cost_q [3];
   logic [5:0] ei_q;
   logic [`FMC_CNT_W-1:0] cnt_q;
   logic [2:0] rdw_q;
   logic in_ready_q;
   logic busy_q;
   logic proc_done_q;
   logic done_all_q;
   logic out_mem_v_q;
   logic out_vid_v_q;
   logic [7:0] out_data_q;
   logic [15:0] sa_q;
   logic [7:0] sd_q;
   logic sd_oe_q;
   logic swe_q;
   logic soe_q;
   logic [7:0] sd_s1_q;
   logic [7:0] sd_s2_q;
   logic [7:0] sd_s3_q;

   // prediction difference of byte i under one encoding type
   function automatic logic [7:0] fmc_diff(fmc_enc_e enc, logic [4:0] i);
      logic [7:0] l;
      logic [8:0] s;
      l = (i == 5'h00) ? left_q : cur_q[i - 5'h01];
      s = {1'b0, l} + {1'b0, up_q[i]};
      case (enc)
         FMC_ENC_LEFT: fmc_diff = cur_q[i] - l;
         FMC_ENC_UP: fmc_diff = cur_q[i] - up_q[i];
         FMC_ENC_AVG: fmc_diff = cur_q[i] - s[8:1];
         FMC_ENC_XOR: fmc_diff = cur_q[i] ^ up_q[i];
         default: fmc_diff = cur_q[i];
      endcase
   endfunction : fmc_diff

   // one byte of the nonzero map, bit k set when byte 8j+k differs
   function automatic logic [7:0] fmc_map(fmc_enc_e enc, logic [1:0] j);
      logic [7:0] m;
      m = 8'h00;
      for (int k = 0; k < 8; k++) begin
         m[k] = (fmc_diff(enc, {j, 3'(k)}) != 8'h00);
      end
      fmc_map = m;
   endfunction : fmc_map

   // fifo and drain stage
   logic push;
   logic [7:0] push_data;
   logic fifo_ready;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic fifo_empty;
   logic out_rdy;
   logic pop;

   fmc_fifo #(.WIDTH(`FMC_FIFO_WIDTH), .DEPTH(`FMC_FIFO_DEPTH)) u_fifo (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(push),
      .in_data_in(push_data),
      .in_ready_out(fifo_ready),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(pop),
      .empty_out(fifo_empty)
   );

   // one destination per operation
   assign out_rdy = cmd_q.to_video ? out_vid_ready_in : out_mem_ready_in;
   assign pop = fifo_valid && (!(out_mem_v_q || out_vid_v_q) || out_rdy);

   // emit decode
   wire in_take = in_ready_q && in_valid_in;
   wire is_pass = (cmd_q.mode == FMC_MODE_PASS);
   wire at_limit = (cnt_q == cmd_q.out_limit);
   wire [4:0] di = 5'(ei_q - `FMC_EMIT_DATA0);
   logic [7:0] di_val;
   logic [7:0] map_byte;
   wire [7:0] pass_byte = word_q[{ei_q[1:0], 3'h0} +: 8];
   wire [7:0] cur_byte = word_q[{bi_q[1:0], 3'h0} +: 8];
   // process form so buffer reads inside the functions wake it up
   always_comb begin
      di_val = fmc_diff(enc_q, di);
      map_byte = fmc_map(enc_q, 2'(ei_q - `FMC_EMIT_MAP0));
   end
   wire emit_hdr = !is_pass && (ei_q == 6'h00);
   wire emit_map = !is_pass && (enc_q != FMC_ENC_RAW)
      && (ei_q >= `FMC_EMIT_MAP0) && (ei_q < `FMC_EMIT_DATA0);
   wire emit_dat = !is_pass && (ei_q >= `FMC_EMIT_DATA0)
      && ((enc_q == FMC_ENC_RAW) || (di_val != 8'h00));
   wire want = (state_q == FMC_ST_EMIT) && !at_limit
      && (is_pass || emit_hdr || emit_map || emit_dat);
   wire emit_end = is_pass ? (ei_q == `FMC_PASS_END)
                           : (ei_q == `FMC_EMIT_END);
   assign push = want && fifo_ready;
   assign push_data = is_pass ? pass_byte
      : emit_hdr ? {5'h00, enc_q}
      : emit_map ? map_byte
      : (enc_q == FMC_ENC_RAW) ? cur_q[di] : di_val;
   wire emit_step = !want || fifo_ready;

   // block scoring: bitmap form costs map bytes plus nonzero bytes
   wire [5:0] sz_l = cost_q[0] + `FMC_MAP_SIZE;
   wire [5:0] sz_u = cost_q[1] + `FMC_MAP_SIZE;
   wire [5:0] sz_a = cost_q[2] + `FMC_MAP_SIZE;
   wire l_best = (sz_l <= sz_u) && (sz_l <= sz_a);
   wire u_best = !l_best && (sz_u <= sz_a);
   wire [5:0] sz_best = l_best ? sz_l : (u_best ? sz_u : sz_a);
   logic [7:0] ev_l;
   logic [7:0] ev_u;
   logic [7:0] ev_a;
   always_comb begin
      ev_l = fmc_diff(FMC_ENC_LEFT, ei_q[4:0]);
      ev_u = fmc_diff(FMC_ENC_UP, ei_q[4:0]);
      ev_a = fmc_diff(FMC_ENC_AVG, ei_q[4:0]);
   end
   wire [15:0] col_nx = (col_q == cmd_q.line_len - 16'h0001)
      ? 16'h0000 : col_q + 16'h0001;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sd_s1_q <= 8'h00;
         sd_s2_q <= 8'h00;
         sd_s3_q <= 8'h00;
      end else begin
         sd_s1_q <= line_sram_data_in;
         sd_s2_q <= sd_s1_q;
         sd_s3_q <= sd_s2_q;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out_mem_v_q <= 1'b0;
         out_vid_v_q <= 1'b0;
         out_data_q <= 8'h00;
         done_all_q <= 1'b0;
      end else begin
         if (pop) begin
            out_data_q <= fifo_data;
            out_mem_v_q <= !cmd_q.to_video;
            out_vid_v_q <= cmd_q.to_video;
         end else if (out_rdy) begin
            out_mem_v_q <= 1'b0;
            out_vid_v_q <= 1'b0;
         end
         if (state_q == FMC_ST_IDLE && start_in) begin
            done_all_q <= 1'b0;
         end else if (proc_done_q && fifo_empty && !pop
                      && !((out_mem_v_q || out_vid_v_q) && !out_rdy)) begin
            done_all_q <= 1'b1;
         end
      end
   end

   // block buffer carries no reset; it is refilled before every use
   always_ff @(posedge core_clk_in) begin
      if (state_q == FMC_ST_SRD && rdw_q == `FMC_RD_WAIT) begin
         up_q[bi_q] <= sd_s3_q;
         cur_q[bi_q] <= cur_byte;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= FMC_ST_IDLE;
         cmd_q <= '0;
         enc_q <= FMC_ENC_RAW;
         word_q <= 32'h0000_0000;
         last_q <= 1'b0;
         bi_q <= 5'h00;
         col_q <= 16'h0000;
         first_line_q <= 1'b1;
         blk_first_q <= 1'b1;
         left_q <= 8'h00;
         cost_q <= '{default: 6'h00};
         ei_q <= 6'h00;
         cnt_q <= 24'h00_0000;
         rdw_q <= 3'h0;
         in_ready_q <= 1'b0;
         busy_q <= 1'b0;
         proc_done_q <= 1'b0;
         sa_q <= 16'h0000;
         sd_q <= 8'h00;
         sd_oe_q <= 1'b0;
         swe_q <= 1'b0;
         soe_q <= 1'b0;
      end else begin
         swe_q <= 1'b0;
         sd_oe_q <= 1'b0;
         if (push) cnt_q <= cnt_q + 24'h00_0001;
         case (state_q)
            FMC_ST_IDLE: begin
               if (start_in) begin
                  cmd_q <= cmd_in;
                  proc_done_q <= 1'b0;
                  cnt_q <= 24'h00_0000;
                  col_q <= 16'h0000;
                  first_line_q <= 1'b1;
                  bi_q <= 5'h00;
                  left_q <= 8'h00;
                  busy_q <= 1'b1;
                  in_ready_q <= 1'b1;
                  state_q <= FMC_ST_FETCH;
               end
            end
            FMC_ST_FETCH: begin
               if (in_take) begin
                  word_q <= in_word_in;
                  last_q <= in_last_in;
                  in_ready_q <= 1'b0;
                  ei_q <= 6'h00;
                  rdw_q <= 3'h0;
                  if (bi_q == 5'h00) blk_first_q <= first_line_q;
                  sa_q <= col_q;
                  soe_q <= !is_pass;
                  state_q <= is_pass ? FMC_ST_EMIT : FMC_ST_SRD;
               end
            end
            FMC_ST_SRD: begin
               rdw_q <= rdw_q + 3'h1;
               if (rdw_q == `FMC_RD_WAIT) begin
                  soe_q <= 1'b0;
                  sd_q <= cur_byte;
                  sd_oe_q <= 1'b1;
                  swe_q <= 1'b1;
                  state_q <= FMC_ST_SWR;
               end
            end
            FMC_ST_SWR: begin
               col_q <= col_nx;
               if (col_nx == 16'h0000) first_line_q <= 1'b0;
               bi_q <= bi_q + 5'h01;
               rdw_q <= 3'h0;
               ei_q <= 6'h00;
               cost_q <= '{default: 6'h00};
               if (bi_q == `FMC_BLK_LAST) begin
                  if (cmd_q.mode == FMC_MODE_BILEVEL) begin
                     enc_q <= FMC_ENC_XOR;
                     state_q <= FMC_ST_EMIT;
                  end else if (blk_first_q) begin
                     enc_q <= FMC_ENC_LEFT;
                     state_q <= FMC_ST_EMIT;
                  end else begin
                     state_q <= FMC_ST_EVAL;
                  end
               end else if (bi_q[1:0] == 2'h3) begin
                  in_ready_q <= 1'b1;
                  state_q <= FMC_ST_FETCH;
               end else begin
                  sa_q <= col_nx;
                  soe_q <= 1'b1;
                  state_q <= FMC_ST_SRD;
               end
            end
            FMC_ST_EVAL: begin
               ei_q <= ei_q + 6'h01;
               if (ei_q == 6'h20) begin
                  ei_q <= 6'h00;
                  if (sz_best >= `FMC_RAW_SIZE) begin
                     enc_q <= FMC_ENC_RAW;
                  end else begin
                     enc_q <= l_best ? FMC_ENC_LEFT
                        : (u_best ? FMC_ENC_UP : FMC_ENC_AVG);
                  end
                  state_q <= FMC_ST_EMIT;
               end else begin
                  state_q <= FMC_ST_EVAL;
                  cost_q[0] <= cost_q[0] + 6'(ev_l != 8'h00);
                  cost_q[1] <= cost_q[1] + 6'(ev_u != 8'h00);
                  cost_q[2] <= cost_q[2] + 6'(ev_a != 8'h00);
               end
            end
            FMC_ST_EMIT: begin
               if (at_limit) begin
                  state_q <= FMC_ST_FINISH;
               end else if (emit_step) begin
                  ei_q <= ei_q + 6'h01;
                  if (emit_end) begin
                     if (!is_pass) left_q <= (col_q == 16'h0000)
                        ? 8'h00 : cur_q[`FMC_BLK_LAST];
                     bi_q <= 5'h00;
                     in_ready_q <= !last_q;
                     state_q <= last_q ? FMC_ST_FINISH : FMC_ST_FETCH;
                  end
               end
            end
            FMC_ST_FINISH: begin
               in_ready_q <= 1'b0;
               proc_done_q <= 1'b1;
               busy_q <= 1'b0;
               state_q <= FMC_ST_IDLE;
            end
            default: begin
               busy_q <= 1'b0;
               state_q <= FMC_ST_IDLE;
            end
         endcase
      end
   end

   // eval runs 33 cycles: 32 scoring steps then the choice
   assign busy_out = busy_q;
   assign proc_done_out = proc_done_q;
   assign done_all_out = done_all_q;
   assign in_ready_out = in_ready_q;
   assign out_data_out = out_data_q;
   assign out_mem_valid_out = out_mem_v_q;
   assign out_vid_valid_out = out_vid_v_q;
   assign line_sram_addr_out = sa_q;
   assign line_sram_data_out = sd_q;
   assign line_sram_data_oe_out = sd_oe_q;
   assign line_sram_write_strobe_out = swe_q;
   assign line_sram_output_strobe_out = soe_q;
endmodule : fmc_codec
`default_nettype wire

//--- verif/fmc_line_sram_model.sv
// line memory model standing on the codec's far side
`default_nettype none
module fmc_line_sram_model #(
   parameter int unsigned RD_LAT = 1
) (
   // clock
   input wire logic clk_in,
   // codec pins
   input wire logic [15:0] addr_in,
   input wire logic [7:0] dev_data_in,
   input wire logic dev_oe_in,
   input wire logic write_strobe_in,
   input wire logic output_strobe_in,
   // resolved data bus level
   output logic [7:0] bus_out
);
   timeunit 1ns;
   timeprecision 1ns;
   bit [7:0] mem [0:65535];
   logic [7:0] last_q = 8'h00;
   int unsigned age_q = 0;
   wire logic rd_ok = output_strobe_in && !dev_oe_in && age_q >= RD_LAT;
   // released bus toggles so a stale byte never looks valid
   assign bus_out = dev_oe_in ? dev_data_in :
      rd_ok ? mem[addr_in] : ~last_q;
   // write lands on the strobe edge; reads show once the strobe has aged
   always @(posedge clk_in) begin
      if (write_strobe_in) mem[addr_in] <= dev_data_in;
      age_q <= output_strobe_in ? age_q + 1 : 0;
      last_q <= bus_out;
   end
endmodule : fmc_line_sram_model
`default_nettype wire

//--- verif/fmc_codec_asserts.sv
// assertion checker watching the frame memory codec ports
`default_nettype none
module fmc_codec_asserts
   import fmc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // control
   input wire logic start_in,
   input wire logic busy_out,
   input wire logic proc_done_out,
   input wire logic done_all_out,
   // output bytes
   input wire logic [7:0] out_data_out,
   input wire logic out_mem_valid_out,
   input wire logic out_mem_ready_in,
   input wire logic out_vid_valid_out,
   // line memory
   input wire logic line_sram_data_oe_out,
   input wire logic line_sram_write_strobe_out,
   input wire logic line_sram_output_strobe_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic take = start_in && !busy_out;

   a_one_dest:
      assert property (!(out_mem_valid_out && out_vid_valid_out))
      else $error("both output sides valid");
   a_drain_order:
      assert property (done_all_out |-> proc_done_out)
      else $error("drained flag without finished flag");
   a_start_clears:
      assert property (take |=> busy_out && !proc_done_out && !done_all_out)
      else $error("start did not clear flags");
   a_flag_holds:
      assert property (proc_done_out && !take |=> proc_done_out)
      else $error("finished flag dropped early");
   a_drain_holds:
      assert property (done_all_out && !take |=> $stable(done_all_out))
      else $error("drained flag dropped early");
   a_done_idle:
      assert property ($rose(proc_done_out) |-> !busy_out)
      else $error("finished while busy");
   a_single_op:
      assert property (busy_out |-> !proc_done_out && !done_all_out)
      else $error("flags set during operation");
   a_drained_empty:
      assert property ($rose(done_all_out) |->
         !out_mem_valid_out && !out_vid_valid_out)
      else $error("drained flag with output pending");
   a_out_hold:
      assert property (out_mem_valid_out && !out_mem_ready_in |=>
         out_mem_valid_out && $stable(out_data_out))
      else $error("output byte not held");
   a_write_pulse:
      assert property (line_sram_write_strobe_out |->
         line_sram_data_oe_out && !line_sram_output_strobe_out
         ##1 !line_sram_write_strobe_out)
      else $error("bad line memory write");
   a_read_first:
      assert property ($rose(line_sram_write_strobe_out) |->
         $past(line_sram_output_strobe_out, 5))
      else $error("write without read of line above");

   c_early_done: cover property (proc_done_out && !done_all_out);
   c_drained: cover property ($rose(done_all_out));
   c_line_wr: cover property (line_sram_write_strobe_out);
endmodule : fmc_codec_asserts
bind fmc_codec fmc_codec_asserts fmc_codec_asserts_inst (.*);
`default_nettype wire

//--- verif/testbench.sv
// self-checking testbench of the frame memory codec
`include "fmc_consts.svh"
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t: %h %h", $time, g, e); end end
module testbench
   import fmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic start_in = 1'b0;
   fmc_cmd_s cmd_in = '0;
   logic in_valid_in = 1'b0;
   logic [31:0] in_word_in = 32'h0;
   logic in_last_in = 1'b0;
   logic out_mem_ready_in = 1'b0;
   logic out_vid_ready_in = 1'b0;
   logic busy_out, proc_done_out, done_all_out, in_ready_out;
   logic [7:0] out_data_out, line_sram_data_out, line_sram_data_in;
   logic out_mem_valid_out, out_vid_valid_out, line_sram_data_oe_out;
   logic [15:0] line_sram_addr_out;
   logic line_sram_write_strobe_out, line_sram_output_strobe_out;
   int err_total = 0;
   int n_tests = 0;
   int taken = 0;
   logic [7:0] mem_q[$], vid_q[$], exp_q[$];

   fmc_codec fmc_codec_inst (.*);
   fmc_line_sram_model #(.RD_LAT(1)) fmc_line_sram_model_inst (
      .clk_in(core_clk_in), .addr_in(line_sram_addr_out),
      .dev_data_in(line_sram_data_out), .dev_oe_in(line_sram_data_oe_out),
      .write_strobe_in(line_sram_write_strobe_out),
      .output_strobe_in(line_sram_output_strobe_out),
      .bus_out(line_sram_data_in));

   always #25 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      if (in_valid_in && in_ready_out === 1'b1) taken++;
      if (out_mem_valid_out === 1'b1 && out_mem_ready_in)
         mem_q.push_back(out_data_out);
      if (out_vid_valid_out === 1'b1 && out_vid_ready_in)
         vid_q.push_back(out_data_out);
   end

   function automatic logic [7:0] pat(input int kind, input int k);
      case (kind)
         0: return 8'(k * 5 + 3);
         1: return (k < 64) ? 8'(16 + 3 * (k % 32)) : 8'(7 * (k % 32) + 1);
         default: return 8'h00;
      endcase
   endfunction : pat

   task automatic go(input fmc_mode_e m, input logic v, input logic [23:0] n);
      @(posedge core_clk_in);
      start_in <= 1'b1;
      cmd_in <= '{m, v, n, 16'h0020};
      @(posedge core_clk_in);
      start_in <= 1'b0;
      mem_q = {};
      vid_q = {};
      exp_q = {};
      taken = 0;
      @(posedge core_clk_in);
      `CHK({busy_out, proc_done_out, done_all_out}, 3'h4)
   endtask : go

   // whole 32-byte blocks only; the supplier pads
   task automatic feed(input int kind, input int words);
      int t;
      for (int w = 0; w < words; w++) begin
         in_valid_in <= 1'b1;
         in_word_in <= {pat(kind, 4 * w + 3), pat(kind, 4 * w + 2),
            pat(kind, 4 * w + 1), pat(kind, 4 * w)};
         in_last_in <= (w == words - 1);
         t = 0;
         do begin
            @(posedge core_clk_in);
            t++;
         end while (in_ready_out !== 1'b1 && proc_done_out !== 1'b1 &&
            t < 3000);
         `CHK(t < 3000, 1'b1)
      end
      in_valid_in <= 1'b0;
      in_last_in <= 1'b0;
   endtask : feed

   task automatic wait_done();
      int t = 0;
      while (done_all_out !== 1'b1 && t < 20000) begin
         @(posedge core_clk_in);
         t++;
      end
      `CHK(proc_done_out, 1'b1)
      `CHK(done_all_out, 1'b1)
   endtask : wait_done

   task automatic cmp(input logic [7:0] q[$]);
      `CHK(q.size(), exp_q.size())
      foreach (exp_q[i]) `CHK(q[i], exp_q[i])
   endtask : cmp

   task automatic t_pass_stall();
      go(FMC_MODE_PASS, 1'b0, 24'd96);
      fork
         feed(0, 24);
         begin
            repeat (600) @(posedge core_clk_in);
            `CHK(taken >= 16 && taken < 24, 1'b1)
            out_mem_ready_in <= 1'b1;
         end
      join
      wait_done();
      for (int k = 0; k < 96; k++) exp_q.push_back(pat(0, k));
      cmp(mem_q);
      `CHK(vid_q.size(), 0)
   endtask : t_pass_stall

   task automatic t_limit_video();
      int t = 0;
      go(FMC_MODE_PASS, 1'b1, 24'd5);
      feed(0, 8);
      while (proc_done_out !== 1'b1 && t < 2000) begin
         @(posedge core_clk_in);
         t++;
      end
      repeat (20) @(posedge core_clk_in);
      `CHK({proc_done_out, done_all_out}, 2'h2)
      out_vid_ready_in <= 1'b1;
      wait_done();
      for (int k = 0; k < 5; k++) exp_q.push_back(pat(0, k));
      cmp(vid_q);
      `CHK(mem_q.size(), 0)
   endtask : t_limit_video

   task automatic t_byte();
      go(FMC_MODE_BYTE, 1'b0, 24'd75);
      fork
         feed(1, 24);
         begin
            repeat (100) @(posedge core_clk_in);
            start_in <= 1'b1;
            cmd_in <= '{FMC_MODE_PASS, 1'b1, 24'd1, 16'h0020};
            @(posedge core_clk_in);
            start_in <= 1'b0;
         end
      join
      wait_done();
      exp_q = {`FMC_HDR_LEFT, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h10};
      repeat (31) exp_q.push_back(8'h03);
      exp_q.push_back(`FMC_HDR_UP);
      repeat (4) exp_q.push_back(8'h00);
      exp_q.push_back(`FMC_HDR_RAW);
      for (int c = 0; c < 32; c++) exp_q.push_back(pat(1, 64 + c));
      cmp(mem_q);
      `CHK(vid_q.size(), 0)
   endtask : t_byte

   task automatic t_bilevel();
      go(FMC_MODE_BILEVEL, 1'b0, 24'd0);
      feed(2, 8);
      wait_done();
      `CHK(mem_q.size(), 0)
      // line above is now all zero; the image header stays with the cpu
      go(FMC_MODE_BILEVEL, 1'b0, 24'd6);
      feed(2, 8);
      wait_done();
      exp_q = {`FMC_HDR_XOR, 8'h00, 8'h00, 8'h00, 8'h00};
      cmp(mem_q);
   endtask : t_bilevel

   task automatic summarize();
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (60000) @(posedge core_clk_in);
      err_total++;
      summarize();
   end

   initial begin
      repeat (5) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      t_pass_stall();
      t_limit_video();
      t_byte();
      t_bilevel();
      summarize();
   end
endmodule : testbench
`default_nettype wire
